// file: rtl/occ_regs.svh
// Purpose: register codes, reset values and field masks of the channel block
// Assumes: included by bare name from every design file
// Notes: write masks keep fixed bits at their documented levels
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

`define OCC_NCH 10
`define OCC_REG_W 12
`define OCC_SEL_A_CH 6

`define OCC_ADDR_ON_BITS 2'h0
`define OCC_ADDR_SEL_A 2'h1
`define OCC_ADDR_SEL_B 2'h2
`define OCC_ADDR_PAIR 2'h3

`define OCC_RST_ON_BITS 12'hC00
`define OCC_RST_SEL_A 12'hAAA
`define OCC_RST_SEL_B 12'h0AA
`define OCC_RST_PAIR 12'h000

`define OCC_WMASK_ON_BITS 12'h3FF
`define OCC_FIXED_ON_BITS 12'hC00
`define OCC_WMASK_SEL_A 12'hFFF
`define OCC_WMASK_SEL_B 12'h0FF
`define OCC_WMASK_PAIR 12'h0F7

`define OCC_SEL_INPUT 2'h2
`define OCC_SEL_AND 2'h3
`define OCC_SEL_PIN_BIT 1

`endif

// file: rtl/occ_pkg.sv
// Purpose: types shared by the channel control block
// Assumes: constants come from occ_regs.svh
// Notes: all block state except the reset synchronizer lives in one packed struct
`include "occ_regs.svh"
package occ_pkg;
    typedef logic [1:0] occ_sel_t;
    typedef logic [`OCC_REG_W-1:0] occ_reg_t;
    typedef logic [`OCC_NCH-1:0] occ_chan_t;

    typedef struct packed {
        occ_reg_t on_bits;
        occ_reg_t sel_a;
        occ_reg_t sel_b;
        occ_reg_t pair;
        logic cs_n_prev;
        occ_chan_t drive;
        occ_chan_t pin_feedback;
        occ_chan_t diag;
    } occ_state_s;
endpackage : occ_pkg

// file: rtl/occ_chan_mux.sv
// Purpose: drive decision of one output channel from its selected source
// Assumes: selector, on bit and pin are synchronous to the clock
// Notes: purely combinational, registered by the caller
`include "occ_regs.svh"
module occ_chan_mux
    import occ_pkg::*;
(
    input wire occ_sel_t i_sel,
    input wire logic i_on,
    input wire logic i_pin,
    output logic o_drive
);
    always_comb
    begin
        o_drive = i_on;
        if (i_sel == `OCC_SEL_INPUT)
        begin
            o_drive = i_pin;
        end
        else if (i_sel == `OCC_SEL_AND)
        begin
            o_drive = i_on & i_pin;
        end
    end
endmodule : occ_chan_mux

// file: rtl/occ_top.sv
// Purpose: output channel drive control for ten low-side channels
// Assumes: register writes arrive already decoded from the serial frames
// Notes: fixed register bits ignore writes and always read back fixed
`include "occ_regs.svh"
module occ_top
    import occ_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_addr,
    input wire occ_reg_t i_wr_data,
    input wire occ_chan_t i_channel_input_pin,
    input wire logic i_cs_n,
    input wire occ_chan_t i_fault,
    output occ_chan_t o_output_channel,
    output occ_reg_t o_channel_on_bit,
    output occ_reg_t o_drive_source_bank_a,
    output occ_reg_t o_drive_source_bank_b,
    output occ_reg_t o_pair_enable,
    output occ_chan_t o_pin_feedback,
    output occ_chan_t o_diag
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    occ_state_s st_q;
    occ_state_s st_d;
    occ_chan_t own_drive;
    occ_chan_t paired_drive;
    logic [`OCC_NCH-1:0] link;
    logic [2*`OCC_NCH-1:0] sel_all;

    // reset held until two clean edges after release
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // channels 1-6 in bank a, 7-10 in bank b low byte
    assign sel_all = {st_q.sel_b[7:0], st_q.sel_a};
    // link[i] ties channel i to channel i-1; no link across groups
    assign link = {st_q.pair[7:5], 1'b0, st_q.pair[4], 1'b0,
                   st_q.pair[2:0], 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < `OCC_NCH; gi++)
        begin : g_chan
            occ_chan_mux u_mux (
                .i_sel(sel_all[2*gi+1:2*gi]),
                .i_on(st_q.on_bits[gi]),
                .i_pin(i_channel_input_pin[gi]),
                .o_drive(own_drive[gi])
            );
            if (gi == 0)
            begin : g_first
                assign paired_drive[gi] = own_drive[gi];
            end
            else
            begin : g_rest
                // chained pairs follow the lowest channel of the gang
                assign paired_drive[gi] = link[gi] ? paired_drive[gi-1]
                                                   : own_drive[gi];
            end
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        if (i_wr_en)
        begin
            case (i_wr_addr)
                `OCC_ADDR_ON_BITS:
                    st_d.on_bits = (i_wr_data & `OCC_WMASK_ON_BITS)
                                   | `OCC_FIXED_ON_BITS;
                `OCC_ADDR_SEL_A:
                    st_d.sel_a = i_wr_data & `OCC_WMASK_SEL_A;
                `OCC_ADDR_SEL_B:
                    st_d.sel_b = i_wr_data & `OCC_WMASK_SEL_B;
                `OCC_ADDR_PAIR:
                    st_d.pair = i_wr_data & `OCC_WMASK_PAIR;
                default:
                    st_d = st_q;
            endcase
        end
        st_d.drive = paired_drive;
        st_d.cs_n_prev = i_cs_n;
        if (st_q.cs_n_prev && !i_cs_n)
        begin
            for (int i = 0; i < `OCC_NCH; i++)
            begin
                // serial channels report their on bit instead
                st_d.pin_feedback[i] = sel_all[2*i+`OCC_SEL_PIN_BIT]
                    ? i_channel_input_pin[i] : st_q.on_bits[i];
            end
        end
        // no merging with the partner: mismatch stays visible
        st_d.diag = i_fault;
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.on_bits <= `OCC_RST_ON_BITS;
            st_q.sel_a <= `OCC_RST_SEL_A;
            st_q.sel_b <= `OCC_RST_SEL_B;
            st_q.pair <= `OCC_RST_PAIR;
            st_q.cs_n_prev <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_output_channel = st_q.drive;
    assign o_channel_on_bit = st_q.on_bits;
    assign o_drive_source_bank_a = st_q.sel_a;
    assign o_drive_source_bank_b = st_q.sel_b;
    assign o_pair_enable = st_q.pair;
    assign o_pin_feedback = st_q.pin_feedback;
    assign o_diag = st_q.diag;

    sequence s_cs_fall;
        st_q.cs_n_prev && !i_cs_n;
    endsequence

    sequence s_on_write;
        i_wr_en && i_wr_addr == `OCC_ADDR_ON_BITS;
    endsequence

    AST_ON_FIXED: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_channel_on_bit[11:10] == 2'h3)
        else $error("on/off upper bits not held at one");
    AST_BANK_B_UPPER: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_drive_source_bank_b[11:8] == 4'h0)
        else $error("bank b upper bits not zero");
    AST_PAIR_GROUPS: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_pair_enable[3] == 1'b0 && o_pair_enable[11:8] == 4'h0)
        else $error("pairing bit across groups set");
    AST_SERIAL: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        !o_drive_source_bank_a[1] |=>
        o_output_channel[0] == $past(o_channel_on_bit[0]))
        else $error("serial channel not following on bit");
    AST_INPUT: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_drive_source_bank_a[1:0] == 2'h2 |=>
        o_output_channel[0] == $past(i_channel_input_pin[0]))
        else $error("input mode channel not following pin");
    AST_AND: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_drive_source_bank_a[1:0] == 2'h3 |=> o_output_channel[0] ==
        ($past(i_channel_input_pin[0]) & $past(o_channel_on_bit[0])))
        else $error("and mode channel wrong");
    AST_PAIRED: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_pair_enable[0] |=> o_output_channel[1] == o_output_channel[0])
        else $error("paired channels not matched");
    AST_UNPAIRED: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        !o_pair_enable[0] && o_drive_source_bank_a[3:2] == `OCC_SEL_INPUT
        |=> o_output_channel[1] == $past(i_channel_input_pin[1]))
        else $error("unpaired channel not on its own pin");
    AST_CHAIN: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_pair_enable[0] && o_pair_enable[1] |=>
        o_output_channel[2] == o_output_channel[0])
        else $error("chained pair not following lowest channel");
    // group heads never follow the channel below them
    AST_GROUP_5: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_drive_source_bank_a[9:8] == `OCC_SEL_INPUT |=>
        o_output_channel[4] == $past(i_channel_input_pin[4]))
        else $error("channel 5 ganged across group");
    AST_GROUP_7: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        o_drive_source_bank_b[1:0] == `OCC_SEL_INPUT |=>
        o_output_channel[6] == $past(i_channel_input_pin[6]))
        else $error("channel 7 ganged across group");
    AST_FEEDBACK: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        s_cs_fall ##0 o_drive_source_bank_a[1] |=>
        o_pin_feedback[0] == $past(i_channel_input_pin[0]))
        else $error("pin not sampled at chip select fall");
    AST_FB_SERIAL: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        s_cs_fall ##0 !o_drive_source_bank_a[1] |=>
        o_pin_feedback[0] == $past(o_channel_on_bit[0]))
        else $error("serial channel feedback not its on bit");
    AST_FB_HOLD: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        !(st_q.cs_n_prev && !i_cs_n) |=> $stable(o_pin_feedback))
        else $error("feedback changed without chip select fall");
    AST_DIAG: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        1'b1 |=> o_diag == $past(i_fault))
        else $error("diagnosis bits merged or lost");
    AST_WRITE: assert property (
        @(posedge i_mclk) disable iff (!rst_n)
        s_on_write |=> o_channel_on_bit[9:0] == $past(i_wr_data[9:0]))
        else $error("on/off write not taken next cycle");
    // checked at release, a mid-run reset included
    AST_RST_VALUES: assert property (
        @(posedge i_mclk)
        $rose(rst_n) |-> o_channel_on_bit == `OCC_RST_ON_BITS
        && o_drive_source_bank_a == `OCC_RST_SEL_A
        && o_drive_source_bank_b == `OCC_RST_SEL_B
        && o_pair_enable == `OCC_RST_PAIR)
        else $error("register reset values wrong");
endmodule : occ_top

// file: dv/occ_mcu_model.sv
// Purpose: controller model: register writes, pins, chip select, faults
// Assumes: every input of the block changes at a falling clock edge
// Notes: ganged health of channels 1 and 2 is the OR of both diag bits
module occ_mcu_model
    import occ_pkg::*;
(
    input wire logic i_mclk,
    input wire occ_chan_t i_diag,
    output logic o_wr_en,
    output logic [1:0] o_wr_addr,
    output occ_reg_t o_wr_data,
    output occ_chan_t o_pin,
    output logic o_cs_n,
    output occ_chan_t o_fault,
    output logic o_pair_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_wr_en = 1'b0;
        o_wr_addr = 2'h0;
        o_wr_data = 12'h000;
        o_pin = 10'h000;
        o_cs_n = 1'b1;
        o_fault = 10'h000;
    end
    // strobe held one full clock, so the rising edge sees settled data
    task automatic write(input logic [1:0] addr, input occ_reg_t data);
        @(negedge i_mclk);
        o_wr_en = 1'b1;
        o_wr_addr = addr;
        o_wr_data = data;
        @(negedge i_mclk);
        o_wr_en = 1'b0;
    endtask : write
    // one failing half of a pair must still flag the pair
    assign o_pair_fault = i_diag[0] | i_diag[1];
endmodule : occ_mcu_model

// file: dv/test_occ_top.sv
// Purpose: self-checking bench of the channel control block
// Assumes: controller model drives all block inputs except clock and reset at falling edges
// Notes: waits of two cycles cover write-to-register-to-drive latency
`include "occ_regs.svh"
module test_occ_top
    import occ_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic wr_en;
    logic [1:0] wr_addr;
    occ_reg_t wr_data, on_q, sel_a, sel_b, pair;
    occ_chan_t pin, fault, out_ch, fb, diag;
    logic cs_n, pair_fault;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 i_mclk = ~i_mclk;
    occ_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_wr_en(wr_en),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data),
        .i_channel_input_pin(pin), .i_cs_n(cs_n), .i_fault(fault),
        .o_output_channel(out_ch), .o_channel_on_bit(on_q),
        .o_drive_source_bank_a(sel_a), .o_drive_source_bank_b(sel_b),
        .o_pair_enable(pair), .o_pin_feedback(fb), .o_diag(diag));
    occ_mcu_model u_mcu (.i_mclk(i_mclk), .i_diag(diag), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_pin(pin),
        .o_cs_n(cs_n), .o_fault(fault), .o_pair_fault(pair_fault));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input occ_reg_t got, input occ_reg_t exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (2) @(negedge i_mclk);
    endtask : settle
    // hang guard, far above the roughly 60 cycles the run needs
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (8) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_mclk);
        chk(on_q, 12'hC00);
        chk(sel_a, 12'hAAA);
        chk(sel_b, 12'h0AA);
        chk(pair, 12'h000);
        chk({2'h0, out_ch}, 12'h000);
        u_mcu.o_pin = 10'h2A5;
        settle();
        chk({2'h0, out_ch}, 12'h2A5);
        u_mcu.write(`OCC_ADDR_ON_BITS, 12'h000);
        settle();
        chk(on_q, 12'hC00);
        u_mcu.write(`OCC_ADDR_ON_BITS, 12'h155);
        u_mcu.write(`OCC_ADDR_SEL_A, 12'h000);
        u_mcu.write(`OCC_ADDR_SEL_B, 12'hF00);
        settle();
        chk(sel_b, 12'h000);
        chk({2'h0, out_ch}, 12'h155);
        u_mcu.write(`OCC_ADDR_SEL_A, 12'hFFF);
        u_mcu.write(`OCC_ADDR_SEL_B, 12'h0FF);
        settle();
        chk({2'h0, out_ch}, 12'h005);
        u_mcu.write(`OCC_ADDR_SEL_A, 12'hAAA);
        u_mcu.write(`OCC_ADDR_SEL_B, 12'h0AA);
        u_mcu.write(`OCC_ADDR_PAIR, 12'hFFF);
        u_mcu.o_pin = 10'h001;
        settle();
        chk(pair, 12'h0F7);
        chk({2'h0, out_ch}, 12'h00F);
        u_mcu.o_pin = 10'h051;
        settle();
        chk({2'h0, out_ch}, 12'h3FF);
        u_mcu.o_pin = 10'h3AE;
        settle();
        chk({2'h0, out_ch}, 12'h000);
        u_mcu.o_fault = 10'h001;
        @(negedge i_mclk);
        chk({2'h0, diag}, 12'h001);
        chk({11'h000, pair_fault}, 12'h001);
        u_mcu.o_pin = 10'h2A5;
        @(negedge i_mclk);
        u_mcu.o_cs_n = 1'b0;
        settle();
        chk({2'h0, fb}, 12'h2A5);
        u_mcu.o_pin = 10'h000;
        settle();
        chk({2'h0, fb}, 12'h2A5);
        u_mcu.o_cs_n = 1'b1;
        u_mcu.write(`OCC_ADDR_SEL_A, 12'h000);
        u_mcu.write(`OCC_ADDR_ON_BITS, 12'h00F);
        u_mcu.o_cs_n = 1'b0;
        settle();
        chk({2'h0, fb}, 12'h00F);
        chk({2'h0, out_ch}, 12'h00F);
        // mid-run reset must drop every register at once
        i_resetn = 1'b0;
        @(negedge i_mclk);
        chk(pair, 12'h000);
        chk(sel_a, 12'hAAA);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_mclk);
        chk(on_q, 12'hC00);
        chk({2'h0, out_ch}, 12'h000);
        wrap_up();
    end
endmodule : test_occ_top
